// *** dv/rtc_calendar_tb.sv ***
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module rtc_calendar_tb
   import rtc_cal_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst_n, hour_format_12, cal_write, wr_pm;
   logic        dst_add_hour, dst_sub_hour, shift_req, add_one_second;
   logic [6:0]  async_divider_value;
   logic [14:0] sync_divider_value, subtract_fraction_count;
   logic [7:0]  wr_sec, wr_min, wr_hour, wr_date, wr_month, wr_year;
   logic [2:0]  wr_wday, wday;
   logic        shift_busy, pm;
   logic [15:0] subsecond_value;
   logic [7:0]  sec, min, hour, date, month, year;
   int          err_total = 0;
   int          n_tests = 0;

   always #4 clk = ~clk;

   rtc_calendar rtc_calendar_inst (.clk, .rst_n, .async_divider_value,
      .sync_divider_value, .hour_format_12, .cal_write, .wr_sec, .wr_min,
      .wr_hour, .wr_pm, .wr_wday, .wr_date, .wr_month, .wr_year,
      .dst_add_hour, .dst_sub_hour, .shift_req, .add_one_second,
      .subtract_fraction_count, .shift_busy, .subsecond_value, .sec, .min,
      .hour, .pm, .wday, .date, .month, .year);

   task automatic end_sim;
      $display("errors=%0d checks=%0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   task automatic cal_set(input logic [7:0] h, input logic p,
                          input logic [7:0] mi, s, d, mo, y,
                          input logic [2:0] wd);
      @(negedge clk);
      {wr_hour, wr_pm, wr_min, wr_sec} = {h, p, mi, s};
      {wr_date, wr_month, wr_year, wr_wday} = {d, mo, y, wd};
      cal_write = 1'b1;
      @(negedge clk);
      cal_write = 1'b0;
   endtask

   task automatic cset(input logic [7:0] h, input logic p);
      cal_set(h, p, 8'h00, 8'h00, 8'h05, 8'h06, 8'h24, 3'h2);
   endtask

   // bounded wait for the next seconds step
   task automatic wait_sec;
      logic [7:0] o;
      int i;
      o = sec;
      for (i = 0; i < 400 && sec === o; i++) @(negedge clk);
      if (sec === o) begin
         err_total++;
         end_sim;
      end
   endtask

   task automatic roll(input logic f, input logic [7:0] h, input logic p,
                       input logic [7:0] d, mo, y, input logic [2:0] wd,
                       input logic [7:0] eh, input logic ep,
                       input logic [7:0] ed, emo, ey);
      logic [2:0] ewd;
      hour_format_12 = f;
      cal_set(h, p, 8'h59, 8'h59, d, mo, y, wd);
      wait_sec;
      ewd = (ed === d) ? wd : ((wd == 3'h7) ? 3'h1 : wd + 3'h1);
      `CHK({min, sec}, 16'h0000);
      `CHK({hour, pm}, {eh, ep});
      `CHK({date, month, year}, {ed, emo, ey});
      `CHK(wday, ewd);
   endtask

   task automatic dst(input logic up, input logic [7:0] eh, input logic ep);
      @(negedge clk);
      if (up) dst_add_hour = 1'b1;
      else dst_sub_hour = 1'b1;
      @(negedge clk);
      dst_add_hour = 1'b0;
      dst_sub_hour = 1'b0;
      `CHK({hour, pm}, {eh, ep});
   endtask

   // dup fires a second, different request while busy; it must be ignored
   task automatic shift(input logic a, input logic [14:0] n,
                        input logic dup);
      logic [16:0] e;
      logic [15:0] v;
      logic [7:0]  vs;
      int          cnt;
      @(negedge clk);
      {shift_req, add_one_second, subtract_fraction_count} = {1'b1, a, n};
      @(negedge clk);
      {shift_req, add_one_second, subtract_fraction_count} =
         {dup, ~a, 15'h1234};
      `CHK(shift_busy, 1'b1);
      cnt = 0;
      v = subsecond_value;
      vs = sec;
      while (shift_busy === 1'b1 && cnt < 50) begin
         v = subsecond_value;
         vs = sec;
         @(negedge clk);
         shift_req = 1'b0;
         cnt++;
      end
      if (cnt >= 50) begin
         err_total++;
         end_sim;
      end
      e = {1'b0, v} + {2'b00, n};
      if (e[16]) e = {1'b0, SS_MAX};
      `CHK(subsecond_value, e[15:0]);
      `CHK(sec, a ? bcd_inc(vs) : vs);
      `CHK(cnt <= 32'(async_divider_value) + 1, 1'b1);
   endtask

   initial begin
      rst_n = 1'b0;
      {hour_format_12, cal_write, wr_pm, dst_add_hour} = 4'h0;
      {dst_sub_hour, shift_req, add_one_second} = 3'h0;
      subtract_fraction_count = 15'h0000;
      async_divider_value = 7'h00;
      sync_divider_value = 15'h0014;
      {wr_sec, wr_min, wr_hour, wr_date, wr_month, wr_year} = 48'h0;
      wr_wday = 3'h1;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK({hour, min, sec, pm}, {RST_HOUR, 16'h0000, 1'b0});
      `CHK({date, month, year}, {RST_DATE, RST_MONTH, RST_YEAR});
      `CHK(wday, RST_WDAY);
      `CHK(subsecond_value, {1'b0, SYNC_RST});
      `CHK(shift_busy, 1'b0);
      roll(0, 8'h23, 0, 8'h28, 8'h02, 8'h23, 3'h7, 8'h00, 0, 8'h01, 8'h03,
           8'h23);
      roll(0, 8'h23, 0, 8'h28, 8'h02, 8'h24, 3'h2, 8'h00, 0, 8'h29, 8'h02,
           8'h24);
      roll(0, 8'h23, 0, 8'h29, 8'h02, 8'h24, 3'h3, 8'h00, 0, 8'h01, 8'h03,
           8'h24);
      roll(0, 8'h23, 0, 8'h30, 8'h04, 8'h24, 3'h4, 8'h00, 0, 8'h01, 8'h05,
           8'h24);
      roll(0, 8'h23, 0, 8'h31, 8'h12, 8'h99, 3'h5, 8'h00, 0, 8'h01, 8'h01,
           8'h00);
      roll(0, 8'h09, 0, 8'h15, 8'h06, 8'h24, 3'h5, 8'h10, 0, 8'h15, 8'h06,
           8'h24);
      roll(1, 8'h11, 1, 8'h31, 8'h01, 8'h24, 3'h1, 8'h12, 0, 8'h01, 8'h02,
           8'h24);
      roll(1, 8'h11, 0, 8'h10, 8'h06, 8'h24, 3'h1, 8'h12, 1, 8'h10, 8'h06,
           8'h24);
      roll(1, 8'h12, 1, 8'h10, 8'h06, 8'h24, 3'h1, 8'h01, 1, 8'h10, 8'h06,
           8'h24);
      hour_format_12 = 1'b0;
      cset(8'h10, 0);
      dst(1, 8'h11, 0);
      dst(0, 8'h10, 0);
      cset(8'h23, 0);
      dst(1, 8'h23, 0);
      cset(8'h00, 0);
      dst(0, 8'h00, 0);
      hour_format_12 = 1'b1;
      cset(8'h11, 0);
      dst(1, 8'h12, 1);
      cset(8'h12, 1);
      dst(0, 8'h11, 0);
      cset(8'h01, 1);
      dst(0, 8'h12, 1);
      cset(8'h11, 1);
      dst(1, 8'h11, 1);
      cset(8'h12, 0);
      dst(0, 8'h12, 0);
      hour_format_12 = 1'b0;
      cset(8'h10, 0);
      wait_sec;
      `CHK(subsecond_value, 16'h0014);
      @(negedge clk);
      `CHK(subsecond_value, 16'h0013);
      `CHK(int'(sync_divider_value) - int'(subsecond_value), 1);
      async_divider_value = 7'h03;
      cset(8'h10, 0);
      wait_sec;
      repeat (3) @(negedge clk);
      `CHK(subsecond_value, 16'h0014);
      @(negedge clk);
      `CHK(subsecond_value, 16'h0013);
      sync_divider_value = 15'h03FF;
      cal_set(8'h03, 0, 8'h25, 8'h32, 8'h05, 8'h06, 8'h24, 3'h2);
      shift(0, 15'h0066, 0);
      shift(1, 15'h039A, 1);
      sync_divider_value = 15'h7FFF;
      cset(8'h10, 0);
      shift(0, 15'h7FFF, 0);
      `CHK(subsecond_value > {1'b0, sync_divider_value}, 1'b1);
      `CHK(int'(sync_divider_value) < int'(subsecond_value), 1'b1);
      shift(0, 15'h7FFF, 0);
      end_sim;
   end
endmodule // rtc_calendar_tb

// *** src/rtc_cal_pkg.sv ***
package rtc_cal_pkg;
   localparam int         ASYNC_W       = 7;
   localparam int         SYNC_W        = 15;
   localparam int         SS_W          = 16;
   localparam logic [6:0] ASYNC_RST     = 7'h7F;
   localparam logic [14:0] SYNC_RST     = 15'h00FF;
   localparam logic [15:0] SS_MAX       = 16'hFFFF;
   localparam logic [7:0] SEC_MAX       = 8'h59;
   localparam logic [7:0] MIN_MAX       = 8'h59;
   localparam logic [7:0] HOUR24_MAX    = 8'h23;
   localparam logic [7:0] HOUR12_MAX    = 8'h12;
   localparam logic [7:0] HOUR12_LAST   = 8'h11;
   localparam logic [7:0] YEAR_MAX      = 8'h99;
   localparam logic [7:0] MONTH_MAX     = 8'h12;
   localparam logic [7:0] FEB           = 8'h02;
   localparam logic [7:0] DAYS_28       = 8'h28;
   localparam logic [7:0] DAYS_29       = 8'h29;
   localparam logic [7:0] DAYS_30       = 8'h30;
   localparam logic [7:0] DAYS_31       = 8'h31;
   localparam logic [7:0] BCD_ZERO      = 8'h00;
   localparam logic [7:0] BCD_ONE       = 8'h01;
   localparam logic [2:0] WDAY_FIRST    = 3'h1;
   localparam logic [2:0] WDAY_LAST     = 3'h7;
   localparam logic [7:0] RST_HOUR      = 8'h00;
   localparam logic [7:0] RST_DATE      = 8'h01;
   localparam logic [7:0] RST_MONTH     = 8'h01;
   localparam logic [7:0] RST_YEAR      = 8'h00;
   localparam logic [2:0] RST_WDAY      = 3'h1;
endpackage : rtc_cal_pkg

// *** src/rtc_calendar.sv ***
module rtc_calendar
   import rtc_cal_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [6:0]        async_divider_value,
   input  wire logic [14:0]       sync_divider_value,
   input  wire logic              hour_format_12,
   input  wire logic              cal_write,
   input  wire logic [7:0]        wr_sec,
   input  wire logic [7:0]        wr_min,
   input  wire logic [7:0]        wr_hour,
   input  wire logic              wr_pm,
   input  wire logic [2:0]        wr_wday,
   input  wire logic [7:0]        wr_date,
   input  wire logic [7:0]        wr_month,
   input  wire logic [7:0]        wr_year,
   input  wire logic              dst_add_hour,
   input  wire logic              dst_sub_hour,
   input  wire logic              shift_req,
   input  wire logic              add_one_second,
   input  wire logic [14:0]       subtract_fraction_count,
   output logic                   shift_busy,
   output logic [15:0]            subsecond_value,
   output logic [7:0]             sec,
   output logic [7:0]             min,
   output logic [7:0]             hour,
   output logic                   pm,
   output logic [2:0]             wday,
   output logic [7:0]             date,
   output logic [7:0]             month,
   output logic [7:0]             year
);

   typedef struct packed {
      logic [ASYNC_W-1:0] acnt;
      logic [SS_W-1:0]    ss;
      logic [7:0]         sec;
      logic [7:0]         min;
      logic [7:0]         hour;
      logic               pm;
      logic [2:0]         wday;
      logic [7:0]         date;
      logic [7:0]         month;
      logic [7:0]         year;
      logic               sh_pend;
      logic               sh_add1;
      logic [SYNC_W-1:0]  sh_sub;
   } state_type;

   state_type st_ff;
   state_type nxt_st;
   logic      apre_tick;
   logic      sec_tick;

   // {carry, value}: step a BCD byte from hi back to lo
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
      if (v >= hi)
         bcd_inc = {1'b1, lo};
      else if (v[3:0] == 4'h9)
         bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         bcd_inc = {1'b0, v + 8'h01};
   endfunction

   function automatic logic [7:0] bcd_dec(input logic [7:0] v);
      if (v[3:0] == 4'h0)
         bcd_dec = {v[7:4] - 4'h1, 4'h9};
      else
         bcd_dec = v - 8'h01;
   endfunction

   // leap when the two-digit BCD year is a multiple of four
   function automatic logic [7:0] month_days(input logic [7:0] mo,
                                             input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      if (mo == FEB)
         month_days = leap ? DAYS_29 : DAYS_28;
      else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11)
         month_days = DAYS_30;
      else
         month_days = DAYS_31;
   endfunction

   // {day carry, pm, hour} for one hour forward
   function automatic logic [9:0] hour_fwd(input logic [7:0] h,
                                           input logic       p,
                                           input logic       f12);
      logic [8:0] r;
      r = bcd_inc(h, BCD_ZERO, HOUR24_MAX);
      if (!f12)
         hour_fwd = {r[8], 1'b0, r[7:0]};
      else if (h == HOUR12_MAX)
         hour_fwd = {1'b0, p, BCD_ONE};
      else if (h == HOUR12_LAST)
         hour_fwd = {p, ~p, HOUR12_MAX};
      else
         hour_fwd = {1'b0, p, r[7:0]};
   endfunction

   assign apre_tick = (st_ff.acnt == '0);
   assign sec_tick  = apre_tick && !st_ff.sh_pend && (st_ff.ss == '0);

   always_comb begin
      logic [8:0]  c;
      logic [9:0]  hf;
      logic        step;
      logic [16:0] sum;
      c      = '0;
      hf     = '0;
      step   = 1'b0;
      sum    = '0;
      nxt_st = st_ff;
      nxt_st.acnt = apre_tick ? async_divider_value
                              : st_ff.acnt - 7'h01;
      if (apre_tick) begin
         if (st_ff.sh_pend) begin
            sum = {1'b0, st_ff.ss} + {2'b00, st_ff.sh_sub};
            nxt_st.ss = sum[16] ? SS_MAX : sum[15:0];
            step = st_ff.sh_add1;
            nxt_st.sh_pend = 1'b0;
         end else if (st_ff.ss == '0) begin
            nxt_st.ss = {1'b0, sync_divider_value};
            step = 1'b1;
         end else begin
            nxt_st.ss = st_ff.ss - 16'h0001;
         end
      end
      if (shift_req && !st_ff.sh_pend) begin
         nxt_st.sh_pend = 1'b1;
         nxt_st.sh_add1 = add_one_second;
         nxt_st.sh_sub  = subtract_fraction_count;
      end
      if (step) begin
         c = bcd_inc(st_ff.sec, BCD_ZERO, SEC_MAX);
         nxt_st.sec = c[7:0];
         if (c[8]) begin
            c = bcd_inc(st_ff.min, BCD_ZERO, MIN_MAX);
            nxt_st.min = c[7:0];
            if (c[8]) begin
               hf = hour_fwd(st_ff.hour, st_ff.pm, hour_format_12);
               nxt_st.hour = hf[7:0];
               nxt_st.pm   = hf[8];
               if (hf[9]) begin
                  nxt_st.wday = (st_ff.wday == WDAY_LAST) ? WDAY_FIRST
                                : st_ff.wday + 3'h1;
                  c = bcd_inc(st_ff.date, BCD_ONE,
                              month_days(st_ff.month, st_ff.year));
                  nxt_st.date = c[7:0];
                  if (c[8]) begin
                     c = bcd_inc(st_ff.month, BCD_ONE, MONTH_MAX);
                     nxt_st.month = c[7:0];
                     if (c[8]) begin
                        c = bcd_inc(st_ff.year, BCD_ZERO, YEAR_MAX);
                        nxt_st.year = c[7:0];
                     end
                  end
               end
            end
         end
      end else if (dst_add_hour) begin
         // no day carry: an hour step across midnight is refused
         hf = hour_fwd(st_ff.hour, st_ff.pm, hour_format_12);
         if (!hf[9] && !(!hour_format_12 && st_ff.hour == HOUR24_MAX)) begin
            nxt_st.hour = hf[7:0];
            nxt_st.pm   = hf[8];
         end
      end else if (dst_sub_hour) begin
         if (!hour_format_12) begin
            if (st_ff.hour != BCD_ZERO)
               nxt_st.hour = bcd_dec(st_ff.hour);
         end else if (st_ff.hour == HOUR12_MAX) begin
            if (st_ff.pm) begin
               nxt_st.hour = HOUR12_LAST;
               nxt_st.pm   = 1'b0;
            end
         end else if (st_ff.hour == BCD_ONE) begin
            nxt_st.hour = HOUR12_MAX;
         end else begin
            nxt_st.hour = bcd_dec(st_ff.hour);
         end
      end
      if (cal_write) begin
         nxt_st.sec     = wr_sec;
         nxt_st.min     = wr_min;
         nxt_st.hour    = wr_hour;
         nxt_st.pm      = wr_pm & hour_format_12;
         nxt_st.wday    = wr_wday;
         nxt_st.date    = wr_date;
         nxt_st.month   = wr_month;
         nxt_st.year    = wr_year;
         nxt_st.acnt    = async_divider_value;
         nxt_st.ss      = {1'b0, sync_divider_value};
         nxt_st.sh_pend = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{acnt: ASYNC_RST, ss: {1'b0, SYNC_RST},
                    sec: BCD_ZERO, min: BCD_ZERO, hour: RST_HOUR,
                    pm: 1'b0, wday: RST_WDAY, date: RST_DATE,
                    month: RST_MONTH, year: RST_YEAR,
                    sh_pend: 1'b0, sh_add1: 1'b0, sh_sub: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // counter only leaves through the read-only output
   assign subsecond_value = st_ff.ss;
   assign shift_busy      = st_ff.sh_pend;
   assign sec             = st_ff.sec;
   assign min             = st_ff.min;
   assign hour            = st_ff.hour;
   assign pm              = st_ff.pm;
   assign wday            = st_ff.wday;
   assign date            = st_ff.date;
   assign month           = st_ff.month;
   assign year            = st_ff.year;

   property p_ss_reload;
      @(posedge clk) disable iff (!rst_n)
      sec_tick && !cal_write |=> st_ff.ss == {1'b0, $past(sync_divider_value)};
   endproperty
   a_ss_reload: assert property (p_ss_reload)
      else $error("sub-second did not reload");
   property p_ss_dec;
      @(posedge clk) disable iff (!rst_n)
      apre_tick && !st_ff.sh_pend && st_ff.ss != '0 && !cal_write
      |=> st_ff.ss == $past(st_ff.ss) - 16'h0001;
   endproperty
   a_ss_dec: assert property (p_ss_dec)
      else $error("sub-second did not count down");
   property p_ss_hold;
      @(posedge clk) disable iff (!rst_n)
      !apre_tick && !cal_write |=> $stable(st_ff.ss);
   endproperty
   a_ss_hold: assert property (p_ss_hold)
      else $error("sub-second moved between prescaler ticks");
   property p_shift_add;
      @(posedge clk) disable iff (!rst_n)
      apre_tick && st_ff.sh_pend && !cal_write && !st_ff.ss[15]
      |=> st_ff.ss == $past(st_ff.ss) + {1'b0, $past(st_ff.sh_sub)};
   endproperty
   a_shift_add: assert property (p_shift_add)
      else $error("shift not added to sub-second");
   property p_add_one_second;
      @(posedge clk) disable iff (!rst_n)
      apre_tick && st_ff.sh_pend && st_ff.sh_add1 && !cal_write &&
      st_ff.sec != SEC_MAX |=> st_ff.sec != $past(st_ff.sec);
   endproperty
   a_add_one_second: assert property (p_add_one_second)
      else $error("add-one-second did not step seconds");
   property p_sec_bcd;
      @(posedge clk) disable iff (!rst_n)
      sec_tick && !cal_write && st_ff.sec[3:0] != 4'h9 &&
      st_ff.sec != SEC_MAX |=> st_ff.sec == $past(st_ff.sec) + 8'h01;
   endproperty
   a_sec_bcd: assert property (p_sec_bcd)
      else $error("second did not advance on reload");
   property p_sec_wrap;
      @(posedge clk) disable iff (!rst_n)
      sec_tick && !cal_write && st_ff.sec == SEC_MAX
      |=> st_ff.sec == BCD_ZERO && st_ff.min != $past(st_ff.min);
   endproperty
   a_sec_wrap: assert property (p_sec_wrap)
      else $error("minute carry missing");
   property p_pm_toggle;
      @(posedge clk) disable iff (!rst_n)
      sec_tick && hour_format_12 && !cal_write && st_ff.hour == HOUR12_LAST
      && st_ff.min == MIN_MAX && st_ff.sec == SEC_MAX
      |=> st_ff.hour == HOUR12_MAX && st_ff.pm != $past(st_ff.pm);
   endproperty
   a_pm_toggle: assert property (p_pm_toggle)
      else $error("am/pm did not toggle at twelve");
endmodule // rtc_calendar
